// ---- core/codec_sap_consts.svh ----
`ifndef CODEC_SAP_CONSTS_SVH
`define CODEC_SAP_CONSTS_SVH

// ------------------------------------------------------------
// register map
// ------------------------------------------------------------
`define SAP_CTRL_OFS      8'h00
`define SAP_STAT_OFS      8'h04
`define SAP_CTRL_RST      32'h0000_0000
`define SAP_CTRL_MASK     32'h0003_ffff
`define SAP_RESP_OKAY     2'h0
`define SAP_RESP_SLVERR   2'h2

// ------------------------------------------------------------
// control field positions
// ------------------------------------------------------------
`define SAP_FMT_LSB       0
`define SAP_MASTER_BIT    2
`define SAP_WIDTH_LSB     3
`define SAP_CHAIN_BIT     5
`define SAP_D5MODE_LSB    6
`define SAP_D5OFF_BIT     8
`define SAP_MAINSEL_LSB   9
`define SAP_LLSEL_LSB     12
`define SAP_D5SEL_LSB     15
`define SAP_STAT_FCNT_LSB 16

// ------------------------------------------------------------
// framing and timing
// ------------------------------------------------------------
`define SAP_RX_LAST_BIT   5'd23
`define SAP_SLOT_LAST_BIT 5'd31
`define SAP_RX_BITS       5'd24
`define SAP_CHAIN_DELAY   128
`define SAP_IDX_PRE       10'h3ff
`define SAP_CLK_NS        50
`define SAP_BCLK_HALF_NS  200
`define SAP_BCLK_HALF_CYC (`SAP_BCLK_HALF_NS / `SAP_CLK_NS)

`endif

// ---- core/codec_sap_pkg.sv ----
package codec_sap_pkg;

	// serial formats
	typedef enum logic [1:0] {
		FMT_LJ  = 2'h0,
		FMT_I2S = 2'h1,
		FMT_TDM = 2'h2
	} fmt_e;

	// fifth converter source modes
	typedef enum logic [1:0] {
		D5_TRACK = 2'h0,
		D5_EXT   = 2'h1,
		D5_AUDIO = 2'h2
	} d5_mode_e;

	// pcm output word length in bits
	function automatic logic [4:0] out_bits(input logic [1:0] code);
		case (code)
			2'h0:    out_bits = 5'd16;
			2'h1:    out_bits = 5'd18;
			2'h2:    out_bits = 5'd20;
			default: out_bits = 5'd24;
		endcase
	endfunction

endpackage

// ---- core/sync2.sv ----
// two-stage synchroniser for asynchronous levels
module sync2 #(
	parameter int W = 1
) (
	// clock and reset
	input  wire  logic         clk,
	input  wire  logic         rst_n,
	// levels
	input  wire  logic [W-1:0] d,
	output logic       [W-1:0] q
);

	logic [W-1:0] meta_r;       // first stage, read only by q

	// ------------------------------------------------------------
	// two flops
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			meta_r <= '0;
			q      <= '0;
		end
		else
		begin
			meta_r <= d;
			q      <= meta_r;
		end
	end

endmodule

// ---- core/codec_serial_audio_port.sv ----
`include "codec_sap_consts.svh"

// Contract
// - pcm out 16/18/20/24 bits, in 24 only
// - shift out on fall, sample on rise
// - master pcm slots span 32 bit clocks
// - left justified: msb first edge, left high
// - i2s: msb second edge, left low
// - pcm: inputs 1-2 out a, 3-4 b
// - pcm: in a to dacs 1-2, b 3-4
// - tdm: adc samples in slots 1-4
// - chaining merges up to four devices
// - chaining only while enable bit set
// - tdm slot layout, chained slots repeat input b
// - adc as tdm or two stereo pairs
// - low latency added after delay stage
// - fifth dac: tracking, external, or audio
// - tdm slots 32 clocks, msb justified
// - tdm frame: msb second edge after sync
// - tdm 3-bit source picks slot group
module codec_serial_audio_port
	import codec_sap_pkg::*;
(
	// clock and reset
	input  wire  logic        aclk,
	input  wire  logic        aresetn,
	// axi4-lite write address
	input  wire  logic        awvalid,
	output logic              awready,
	input  wire  logic [7:0]  awaddr,
	input  wire  logic [2:0]  awprot,
	// axi4-lite write data
	input  wire  logic        wvalid,
	output logic              wready,
	input  wire  logic [31:0] wdata,
	input  wire  logic [3:0]  wstrb,
	// axi4-lite write response
	output logic              bvalid,
	input  wire  logic        bready,
	output logic       [1:0]  bresp,
	// axi4-lite read address
	input  wire  logic        arvalid,
	output logic              arready,
	input  wire  logic [7:0]  araddr,
	input  wire  logic [2:0]  arprot,
	// axi4-lite read data
	output logic              rvalid,
	input  wire  logic        rready,
	output logic       [31:0] rdata,
	output logic       [1:0]  rresp,
	// serial link
	input  wire  logic        bclk_in,
	output logic              bclk_out,
	output logic              bclk_oe,
	input  wire  logic        frame_sync_in,
	output logic              frame_sync_out,
	output logic              frame_sync_oe,
	input  wire  logic        serial_in_a,
	input  wire  logic        serial_in_b,
	output logic              serial_out_a,
	output logic              serial_out_b,
	// converter side
	input  wire  logic [23:0] analog_in_one,
	input  wire  logic [23:0] analog_in_two,
	input  wire  logic [23:0] analog_in_three,
	input  wire  logic [23:0] analog_in_four,
	input  wire  logic [23:0] envelope_ref,
	output logic       [23:0] analog_out_one,
	output logic       [23:0] analog_out_two,
	output logic       [23:0] analog_out_three,
	output logic       [23:0] analog_out_four,
	output logic       [23:0] tracking_dac_out,
	output logic              sample_strobe
);

	// ------------------------------------------------------------
	// control fields
	// ------------------------------------------------------------
	logic [31:0] serial_port_control_reg;   // software control word
	logic [1:0]  fmt;                       // selected format code
	logic        is_tdm;                    // tdm format
	logic        is_i2s;                    // i2s format
	logic        master_on;                 // device makes the clocks
	logic        output_chain_enable;       // sidechain active
	logic [4:0]  out_len;                   // pcm output word length
	logic [2:0]  main_dac_slot_select;      // dac1-4 source group
	logic [2:0]  low_latency_slot_select;   // low latency source group
	logic [2:0]  d5_sel;                    // fifth dac source group
	logic [1:0]  d5_mode;                   // fifth dac use
	logic        converter_power_off;       // fifth dac powered down

	assign fmt       = serial_port_control_reg[`SAP_FMT_LSB +: 2];
	assign is_tdm    = (fmt == FMT_TDM);
	assign is_i2s    = (fmt == FMT_I2S);
	assign master_on = serial_port_control_reg[`SAP_MASTER_BIT] & ~is_tdm;
	assign output_chain_enable = serial_port_control_reg[`SAP_CHAIN_BIT] & is_tdm;
	assign out_len   = out_bits(serial_port_control_reg[`SAP_WIDTH_LSB +: 2]);
	assign main_dac_slot_select    = serial_port_control_reg[`SAP_MAINSEL_LSB +: 3];
	assign low_latency_slot_select = serial_port_control_reg[`SAP_LLSEL_LSB +: 3];
	assign d5_sel    = serial_port_control_reg[`SAP_D5SEL_LSB +: 3];
	assign d5_mode   = serial_port_control_reg[`SAP_D5MODE_LSB +: 2];
	assign converter_power_off = serial_port_control_reg[`SAP_D5OFF_BIT];

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic [3:0] pin_s;      // bclk, sync, in a, in b after two flops

	sync2 #(
		.W (4)
	) u_sync (
		.clk   (aclk),
		.rst_n (aresetn),
		.d     ({bclk_in, frame_sync_in, serial_in_a, serial_in_b}),
		.q     (pin_s)
	);

	// ------------------------------------------------------------
	// master clock generator
	// ------------------------------------------------------------
	logic [2:0] div_r;      // aclk cycles within a half bit clock
	logic [5:0] mbit_r;     // bit position within the 64-bit frame
	logic [5:0] mbit_nxt;   // position after the coming falling edge

	assign mbit_nxt = mbit_r + 6'h01;

	// divider, 32 bit clocks per channel half
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !master_on)
		begin
			div_r          <= 3'h0;
			mbit_r         <= 6'h00;
			bclk_out       <= 1'b0;
			frame_sync_out <= 1'b0;
		end
		else if (div_r == 3'(`SAP_BCLK_HALF_CYC - 1))
		begin
			div_r    <= 3'h0;
			bclk_out <= ~bclk_out;
			// sync moves only on the falling edge
			if (bclk_out)
			begin
				mbit_r         <= mbit_nxt;
				frame_sync_out <= is_i2s ? mbit_nxt[5] : ~mbit_nxt[5];
			end
		end
		else
		begin
			div_r <= div_r + 3'h1;
		end
	end

	// pin drivers on while master
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bclk_oe       <= 1'b0;
			frame_sync_oe <= 1'b0;
		end
		else
		begin
			bclk_oe       <= master_on;
			frame_sync_oe <= master_on;
		end
	end

	// ------------------------------------------------------------
	// bit clock edges
	// ------------------------------------------------------------
	logic bclk_now;     // active bit clock level
	logic fs_now;       // active frame sync level
	logic bclk_d_r;     // bit clock one cycle back
	logic rise;         // rising bit clock edge seen
	logic fall;         // falling bit clock edge seen

	assign bclk_now = master_on ? bclk_out : pin_s[3];
	assign fs_now   = master_on ? frame_sync_out : pin_s[2];
	assign rise     = bclk_now & ~bclk_d_r;
	assign fall     = ~bclk_now & bclk_d_r;

	// edge history
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			bclk_d_r <= 1'b0;
		else
			bclk_d_r <= bclk_now;
	end

	// ------------------------------------------------------------
	// framing at the falling edge
	// ------------------------------------------------------------
	logic       fs_ref_r;   // sync level at the last falling edge
	logic [9:0] idx_r;      // bit index sampled at the next rise
	logic [9:0] nx;         // bit index after this falling edge
	logic       start;      // frame or channel boundary
	logic       chan_left;  // channel now on the wire is left
	logic       frame_evt;  // start of a whole frame

	assign start     = is_tdm ? (fs_now & ~fs_ref_r) : (fs_now ^ fs_ref_r);
	assign chan_left = is_i2s ? ~fs_now : fs_now;
	assign frame_evt = fall & start & (is_tdm | chan_left);

	// lj msb on first rise, i2s and tdm one bit later
	always_comb
	begin
		if (!start)
			nx = idx_r + 10'h001;
		else if (is_tdm || is_i2s)
			nx = `SAP_IDX_PRE;
		else
			nx = 10'h000;
	end

	// position tracking
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			fs_ref_r <= 1'b0;
			idx_r    <= `SAP_IDX_PRE;
		end
		else if (fall)
		begin
			fs_ref_r <= fs_now;
			idx_r    <= nx;
		end
	end

	// ------------------------------------------------------------
	// transmit bit selection
	// ------------------------------------------------------------
	logic [23:0] adc_w [4];     // converter samples by channel
	logic [4:0]  tbit;          // bit within the slot
	logic [4:0]  tmsb;          // sample bit for this slot bit
	logic        tx_a;          // next bit for output a
	logic        tx_b;          // next bit for output b
	logic [127:0] dly_r;        // input b delayed by four slots

	assign adc_w[0] = analog_in_one;
	assign adc_w[1] = analog_in_two;
	assign adc_w[2] = analog_in_three;
	assign adc_w[3] = analog_in_four;
	assign tbit     = nx[4:0];
	assign tmsb     = 5'd23 - tbit;

	// msb first, zeros past the word
	always_comb
	begin
		tx_a = 1'b0;
		tx_b = 1'b0;
		if (nx == `SAP_IDX_PRE)
		begin
			tx_a = 1'b0;
		end
		else if (is_tdm)
		begin
			// output b idle in tdm, all on a
			if (nx[9:7] == 3'h0)
			begin
				if (tbit < `SAP_RX_BITS)
					tx_a = adc_w[nx[6:5]][tmsb];
			end
			else if (output_chain_enable && !nx[9])
			begin
				tx_a = dly_r[`SAP_CHAIN_DELAY - 1];
			end
		end
		else if (nx < {5'h00, out_len})
		begin
			tx_a = adc_w[chan_left ? 2'h0 : 2'h1][tmsb];
			tx_b = adc_w[chan_left ? 2'h2 : 2'h3][tmsb];
		end
	end

	// drive data after the falling edge
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			serial_out_a <= 1'b0;
			serial_out_b <= 1'b0;
		end
		else if (fall)
		begin
			serial_out_a <= tx_a;
			serial_out_b <= tx_b;
		end
	end

	// ------------------------------------------------------------
	// receive shifting at the rising edge
	// ------------------------------------------------------------
	logic [31:0] sh_a_r;    // recent bits of input a
	logic [31:0] sh_b_r;    // recent bits of input b
	logic [23:0] word_a;    // 24-bit word ending with this bit, a
	logic [23:0] word_b;    // 24-bit word ending with this bit, b
	logic [7:0]  byte_a;    // low byte ending with this bit, a
	logic        rx_ok;     // this rise carries a slot bit

	assign word_a = {sh_a_r[22:0], pin_s[1]};
	assign word_b = {sh_b_r[22:0], pin_s[0]};
	assign byte_a = {sh_a_r[6:0], pin_s[1]};
	assign rx_ok  = rise && (idx_r != `SAP_IDX_PRE);

	// shift registers and chain delay line
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sh_a_r <= 32'h0000_0000;
			sh_b_r <= 32'h0000_0000;
			dly_r  <= '0;
		end
		else if (rx_ok)
		begin
			sh_a_r <= {sh_a_r[30:0], pin_s[1]};
			sh_b_r <= {sh_b_r[30:0], pin_s[0]};
			dly_r  <= {dly_r[`SAP_CHAIN_DELAY - 2:0], pin_s[0]};
		end
	end

	// ------------------------------------------------------------
	// word capture and routing
	// ------------------------------------------------------------
	logic [23:0] main_r [4];    // dac1-4 words from the link
	logic [23:0] ll_r [4];      // low latency words
	logic [3:0]  rslot;         // tdm slot of this rise
	logic        at_word;       // 24th bit of a slot
	logic        at_end;        // last bit of a slot

	assign rslot   = idx_r[8:5];
	assign at_word = rx_ok && (idx_r[4:0] == `SAP_RX_LAST_BIT);
	assign at_end  = rx_ok && (idx_r[4:0] == `SAP_SLOT_LAST_BIT);

	// main and low latency paths
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (int i = 0; i < 4; i++)
			begin
				main_r[i] <= 24'h000000;
				ll_r[i]   <= 24'h000000;
			end
		end
		else if (!is_tdm)
		begin
			// pcm has no low latency stream
			for (int i = 0; i < 4; i++)
				ll_r[i] <= 24'h000000;
			if (at_word && idx_r[9:5] == 5'h00)
			begin
				main_r[chan_left ? 0 : 1] <= word_a;
				main_r[chan_left ? 2 : 3] <= word_b;
			end
		end
		else if (at_word && !idx_r[9])
		begin
			// four consecutive slots per source group
			if (rslot[3:2] == main_dac_slot_select[1:0])
				main_r[rslot[1:0]] <= main_dac_slot_select[2] ? word_b : word_a;
			if (rslot[3:2] == low_latency_slot_select[1:0])
				ll_r[rslot[1:0]] <= low_latency_slot_select[2] ? word_b : word_a;
		end
	end

	// fifth converter words from input a
	logic [23:0] d5_ext_r;      // tracking word from slot low bytes
	logic [23:0] d5_aud_r;      // audio word from the group's first slot
	logic        d5_hit;        // slot belongs to the fifth dac group

	assign d5_hit = is_tdm && !idx_r[9] && !d5_sel[2] && (rslot[3:2] == d5_sel[1:0]);

	// low bytes of three slots form one word
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			d5_ext_r <= 24'h000000;
			d5_aud_r <= 24'h000000;
		end
		else if (d5_hit)
		begin
			if (at_word && rslot[1:0] == 2'h0)
				d5_aud_r <= word_a;
			if (at_end)
			begin
				case (rslot[1:0])
					2'h0:    d5_ext_r[23:16] <= byte_a;
					2'h1:    d5_ext_r[15:8]  <= byte_a;
					2'h2:    d5_ext_r[7:0]   <= byte_a;
					default: d5_ext_r        <= d5_ext_r;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// converter outputs, updated once per frame
	// ------------------------------------------------------------
	logic [23:0] out_r [4];     // dac1-4 output words
	logic [15:0] frame_cnt_r;   // frames seen

	assign analog_out_one   = out_r[0];
	assign analog_out_two   = out_r[1];
	assign analog_out_three = out_r[2];
	assign analog_out_four  = out_r[3];

	// sum past the delay stage, wraps on overflow
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (int i = 0; i < 4; i++)
				out_r[i] <= 24'h000000;
			tracking_dac_out <= 24'h000000;
			sample_strobe    <= 1'b0;
			frame_cnt_r      <= 16'h0000;
		end
		else
		begin
			sample_strobe <= frame_evt;
			if (frame_evt)
			begin
				frame_cnt_r <= frame_cnt_r + 16'h0001;
				for (int i = 0; i < 4; i++)
					out_r[i] <= main_r[i] + ll_r[i];
				// fifth dac source
				if (converter_power_off)
					tracking_dac_out <= 24'h000000;
				else if (d5_mode == D5_TRACK)
					tracking_dac_out <= envelope_ref;
				else if (!is_tdm)
					tracking_dac_out <= 24'h000000;
				else if (d5_mode == D5_EXT)
					tracking_dac_out <= d5_ext_r;
				else
					tracking_dac_out <= d5_aud_r;
			end
		end
	end

	// ------------------------------------------------------------
	// axi4-lite write channel
	// ------------------------------------------------------------
	logic [7:0] wa_r;       // held write address
	logic [31:0] wd_r;      // held write data
	logic [3:0] ws_r;       // held byte strobes
	logic       aw_have_r;  // address taken
	logic       w_have_r;   // data taken

	// take address and data in either order
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready   <= 1'b0;
			wready    <= 1'b0;
			aw_have_r <= 1'b0;
			w_have_r  <= 1'b0;
			wa_r      <= 8'h00;
			wd_r      <= 32'h0000_0000;
			ws_r      <= 4'h0;
			bvalid    <= 1'b0;
			bresp     <= `SAP_RESP_OKAY;
			serial_port_control_reg <= `SAP_CTRL_RST;
		end
		else
		begin
			if (awvalid && awready)
			begin
				wa_r      <= awaddr;
				aw_have_r <= 1'b1;
				awready   <= 1'b0;
			end
			else if (!aw_have_r && !bvalid)
				awready <= 1'b1;
			if (wvalid && wready)
			begin
				wd_r     <= wdata;
				ws_r     <= wstrb;
				w_have_r <= 1'b1;
				wready   <= 1'b0;
			end
			else if (!w_have_r && !bvalid)
				wready <= 1'b1;
			// commit once both halves are held
			if (aw_have_r && w_have_r && !bvalid)
			begin
				aw_have_r <= 1'b0;
				w_have_r  <= 1'b0;
				bvalid    <= 1'b1;
				if (wa_r == `SAP_CTRL_OFS)
				begin
					bresp <= `SAP_RESP_OKAY;
					for (int b = 0; b < 4; b++)
						if (ws_r[b])
							serial_port_control_reg[b*8 +: 8] <=
								wd_r[b*8 +: 8] & 8'(`SAP_CTRL_MASK >> (b*8));
				end
				else if (wa_r == `SAP_STAT_OFS)
					bresp <= `SAP_RESP_OKAY;
				else
					bresp <= `SAP_RESP_SLVERR;
			end
			else if (bvalid && bready)
				bvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// axi4-lite read channel
	// ------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= `SAP_RESP_OKAY;
		end
		else if (arvalid && arready)
		begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			if (araddr == `SAP_CTRL_OFS)
			begin
				rdata <= serial_port_control_reg;
				rresp <= `SAP_RESP_OKAY;
			end
			else if (araddr == `SAP_STAT_OFS)
			begin
				// frame count high, live mode bits low
				rdata <= {frame_cnt_r, 13'h0000, output_chain_enable, master_on, is_tdm};
				rresp <= `SAP_RESP_OKAY;
			end
			else
			begin
				rdata <= 32'h0000_0000;
				rresp <= `SAP_RESP_SLVERR;
			end
		end
		else if (rvalid && rready)
		begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
		end
		else if (!rvalid)
			arready <= 1'b1;
	end

endmodule

// ---- sim/sap_asserts.sv ----
module sap_asserts (
	// clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// register bus
	input wire logic        awvalid,
	input wire logic        awready,
	input wire logic        wvalid,
	input wire logic        wready,
	input wire logic        bvalid,
	input wire logic        bready,
	input wire logic [1:0]  bresp,
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic        rvalid,
	input wire logic        rready,
	input wire logic [31:0] rdata,
	input wire logic [1:0]  rresp,
	// link and converters
	input wire logic        bclk_in,
	input wire logic        bclk_oe,
	input wire logic        frame_sync_oe,
	input wire logic        serial_out_a,
	input wire logic [23:0] analog_out_one,
	input wire logic        sample_strobe
);
	timeunit 1ns;
	timeprecision 1ns;
	// ------------------------------
	// checks on one clock domain
	// ------------------------------
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
	a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped early");
	a_w_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
		else $error("write response late");
	a_r_answer: assert property (arvalid && arready |=> rvalid)
		else $error("read data late");
	a_err_zero: assert property (rvalid && rresp == 2'h2 |-> rdata == 32'h0)
		else $error("error read with data");
	a_strobe_pulse: assert property (sample_strobe |=> !sample_strobe)
		else $error("frame strobe too long");
	a_dac_frame: assert property ($changed(analog_out_one) |-> sample_strobe)
		else $error("dac word moved mid frame");
	a_tx_fall: assert property ($changed(serial_out_a) && !bclk_oe
		|-> !$past(bclk_in, 3) || !$past(bclk_in, 4))
		else $error("output bit moved on rising side");
	a_oe_pair: assert property (bclk_oe == frame_sync_oe)
		else $error("clock and sync drive differ");
	// main scenarios seen
	c_strobe: cover property (sample_strobe);
	c_slverr: cover property (bvalid && bresp == 2'h2);
	c_tx: cover property ($changed(serial_out_a));
endmodule
bind codec_serial_audio_port sap_asserts chk (.*);

// ---- sim/link_host.sv ----
module link_host (
	// clock
	input  wire logic aclk,
	// link toward the device
	output logic      bclk,
	output logic      fsync,
	output logic      sda,
	output logic      sdb,
	input  wire logic oa,
	input  wire logic ob
);
	timeunit 1ns;
	timeprecision 1ns;
	// ------------------------------
	// slot words sent and caught
	// ------------------------------
	logic [31:0] tx_a [16];
	logic [31:0] tx_b [16];
	logic [31:0] rx_a [16];
	logic [31:0] rx_b [16];
	// bit clock idles high, host is clock source
	initial
	begin
		bclk = 1'b1;
		fsync = 1'b0;
		sda = 1'b0;
		sdb = 1'b0;
	end
	// one frame of n 32-bit slots, clock runs only here
	task automatic frame(input logic [1:0] f, input int n);
		int d;
		int j;
		d = (f == 2'h0) ? 0 : 1;
		for (int i = -1; i < n * 32 + d; i++)
		begin
			j = i - d;
			@(posedge aclk);
			bclk <= 1'b0;
			// sync level or pulse
			fsync <= (f == 2'h2) ? (i == 0) : ((i >= 0 && i < 32) ^ f[0]);
			// drive on fall, inverse when idle
			sda <= (j >= 0 && j < n * 32) ? tx_a[j / 32][31 - j % 32] : ~sda;
			sdb <= (j >= 0 && j < n * 32) ? tx_b[j / 32][31 - j % 32] : ~sdb;
			repeat (4) @(posedge aclk);
			bclk <= 1'b1;
			repeat (3) @(posedge aclk);
			// catch output bits after rise
			if (j >= 0 && j < n * 32)
			begin
				rx_a[j / 32][31 - j % 32] = oa;
				rx_b[j / 32][31 - j % 32] = ob;
			end
		end
	endtask
endmodule

// ---- sim/tb.sv ----
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	// ------------------------------
	// signals
	// ------------------------------
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, bclk_in, bclk_out, bclk_oe;
	logic        frame_sync_in, frame_sync_out, frame_sync_oe, sample_strobe;
	logic        serial_in_a, serial_in_b, serial_out_a, serial_out_b;
	logic [7:0]  awaddr, araddr;
	logic [2:0]  awprot, arprot, ms;
	logic [3:0]  wstrb;
	logic [31:0] wdata, rdata, v, m, t, mw, lw;
	logic [1:0]  bresp, rresp;
	logic [23:0] analog_in_one, analog_in_two, analog_in_three, analog_in_four;
	logic [23:0] analog_out_one, analog_out_two, analog_out_three, analog_out_four;
	logic [23:0] envelope_ref, tracking_dac_out, e;
	logic [23:0] adc [4];
	logic [23:0] dac [4];
	int          error_cnt, checks, c;
	assign analog_in_one = adc[0];
	assign analog_in_two = adc[1];
	assign analog_in_three = adc[2];
	assign analog_in_four = adc[3];
	assign dac = '{analog_out_one, analog_out_two, analog_out_three, analog_out_four};
	codec_serial_audio_port dut (.*);
	link_host host (.aclk(aclk), .bclk(bclk_in), .fsync(frame_sync_in), .sda(serial_in_a),
		.sdb(serial_in_b), .oa(serial_out_a), .ob(serial_out_b));
	initial
	begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	// ------------------------------
	// compare, verdict, bus cycles
	// ------------------------------
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic results;
		$display("counts: %0d checks, %0d mismatches", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int k;
		k = 0;
		@(posedge aclk);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		awaddr <= a;
		wdata <= d;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			k++;
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (!bvalid && k < 50);
		bready <= 1'b0;
		cmp(bresp, er);
		if (k >= 50)
		begin
			error_cnt++;
			results();
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [1:0] er);
		int k;
		k = 0;
		@(posedge aclk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			k++;
			if (arready)
				arvalid <= 1'b0;
		end
		while (!rvalid && k < 50);
		v = rdata;
		rready <= 1'b0;
		cmp(rresp, er);
		if (k >= 50)
		begin
			error_cnt++;
			results();
		end
	endtask
	// slot word picked by a source code
	function automatic logic [31:0] pick(input logic [2:0] s, input int k);
		return s[2] ? host.tx_b[s[1:0] * 4 + k] : host.tx_a[s[1:0] * 4 + k];
	endfunction
	// ------------------------------
	// main sequence
	// ------------------------------
	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, awprot, arprot, wdata} = '0;
		wstrb = 4'hf;
		error_cnt = 0;
		checks = 0;
		void'($urandom(39));
		envelope_ref = $urandom;
		foreach (adc[k]) adc[k] = $urandom;
		foreach (host.tx_a[s]) host.tx_a[s] = $urandom;
		foreach (host.tx_b[s]) host.tx_b[s] = $urandom;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rd(8'h00, 2'h0);
		cmp(v, 32'h0);
		rd(8'h0c, 2'h2);
		cmp(v, 32'h0);
		wr(8'h0c, 32'h1, 2'h2);
		$display("test registers done");
		// left justified then i2s, fifth dac off
		for (int f = 0; f < 2; f++)
		begin
			c = $urandom % 4;
			m = ~(32'hffffffff >> (c == 3 ? 24 : 16 + 2 * c));
			wr(8'h00, f | c << 3 | 32'h100, 2'h0);
			host.frame(f, 2);
			host.frame(f, 2);
			for (int k = 0; k < 4; k++)
			begin
				t = k < 2 ? host.rx_a[k] : host.rx_b[k - 2];
				cmp(t, {adc[k], 8'h00} & m);
				t = k < 2 ? host.tx_a[k] : host.tx_b[k - 2];
				cmp(dac[k], t[31:8]);
			end
			cmp(tracking_dac_out, 32'h0);
			$display("test pcm format %0d done", f);
		end
		// device as clock master, bit clocks counted between sync changes
		wr(8'h00, 32'h104, 2'h0);
		c = 0;
		t = 0;
		m = {bclk_out, frame_sync_out};
		for (int n = 0; n < 2000 && t < 3; n++)
		begin
			@(posedge aclk);
			if (t == 2 && bclk_out && !m[1])
				c++;
			if (frame_sync_out != m[0])
				t++;
			m = {bclk_out, frame_sync_out};
		end
		if (t < 3)
		begin
			error_cnt++;
			results();
		end
		cmp(c, 32);
		cmp(bclk_oe, 32'h1);
		$display("test master clocks done");
		// tdm with master bit refused, every source code, chaining on and off
		for (int i = 0; i < 8; i++)
		begin
			ms = i;
			c = (i + 1) % 4;
			wr(8'h00, 32'h6 | (i & 1) << 5 | ms << 9 | (ms ^ 3'h4) << 12 | (i % 3) << 6 | c << 15,
				2'h0);
			host.frame(2'h2, 16);
			host.frame(2'h2, 16);
			for (int s = 0; s < 16; s++)
			begin
				cmp(host.rx_a[s], s < 4 ? {adc[s], 8'h00} : (i & 1) ? host.tx_b[s - 4] : 0);
				cmp(host.rx_b[s], 32'h0);
			end
			for (int k = 0; k < 4; k++)
			begin
				mw = pick(ms, k);
				lw = pick(ms ^ 3'h4, k);
				e = mw[31:8] + lw[31:8];
				cmp(dac[k], e);
			end
			c = c * 4;
			e = i % 3 == 0 ? envelope_ref : i % 3 == 2 ? host.tx_a[c][31:8]
				: {host.tx_a[c][7:0], host.tx_a[c + 1][7:0], host.tx_a[c + 2][7:0]};
			cmp(tracking_dac_out, e);
			cmp(bclk_oe, 32'h0);
			rd(8'h04, 2'h0);
			cmp(v & 7, (i & 1) << 2 | 1);
			$display("test tdm code %0d done", i);
		end
		results();
	end
endmodule
